//--- core/eld_pkg.sv
package eld_pkg;
	// ========================================
	// register map
	localparam logic [4:0] ADR_RX_BASE  = 5'h00;
	localparam logic [4:0] ADR_TX_BASE  = 5'h04;
	localparam logic [4:0] ADR_STATUS   = 5'h08;
	localparam logic [4:0] ADR_OPMODE   = 5'h0C;
	localparam logic [4:0] ADR_MISSED   = 5'h10;
	localparam logic [4:0] ADR_TX_STAT  = 5'h14;
	localparam logic [4:0] ADR_RX_STAT  = 5'h18;

	// ========================================
	// operating mode register fields
	localparam int OM_LSB        = 0;
	localparam int CMD_TX_START  = 2;
	localparam int CMD_TX_STOP   = 3;
	localparam int CMD_RX_START  = 4;
	localparam int CMD_RX_STOP   = 5;

	// ========================================
	// status register fields
	localparam int ST_TX_LSB     = 0;
	localparam int ST_RX_LSB     = 2;
	localparam int ST_INIT_FAIL  = 4;
	localparam int ST_SHORT      = 5;
	localparam int ST_OPEN       = 6;

	// ========================================
	// tx descriptor status word fields
	localparam int TX_DEFER      = 0;
	localparam int TX_HB_FAIL    = 1;
	localparam int TX_CC_LSB     = 2;
	localparam int TX_EXC_COL    = 6;
	localparam int TX_LATE_COL   = 7;
	localparam int TX_NO_CARRIER = 8;
	localparam int TX_TDR_LSB    = 10;

	// ========================================
	// rx descriptor status word fields
	localparam int RX_OVERFLOW   = 0;
	localparam int RX_CRC_ERR    = 1;
	localparam int RX_DRIBBLE    = 2;
	localparam int RX_TOO_LONG   = 3;
	localparam int RX_FL_LSB     = 16;

	// ========================================
	// widths and reset values
	localparam int CC_W  = 4;
	localparam int TDR_W = 10;
	localparam int FL_W  = 14;
	localparam int MFC_W = 16;
	localparam logic [31:0] ZERO32 = 32'h0000_0000;
	localparam logic [MFC_W-1:0] MFC_ONE = 16'h0001;

	typedef enum logic [1:0] {
		OM_NORMAL   = 2'b00,
		OM_INT_LOOP = 2'b01,
		OM_EXT_LOOP = 2'b10
	} eld_mode_t;

	typedef enum logic [1:0] {
		PS_STOPPED   = 2'b00,
		PS_RUNNING   = 2'b01,
		PS_SUSPENDED = 2'b10
	} eld_pstate_t;
endpackage : eld_pkg

//--- core/eld_loopback.sv
// The Wishbone interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
// Contract
// - internal loopback sends transmit frames to receive path, line output disabled
// - external loopback transmits on line and receives from line concurrently
// - external loopback accepts frames of any origin, no source check
// - loopback keeps normal destination filtering and frame validity checks
// - host stops both, writes normal code; controller resumes normal operation
// - per-frame collision count recorded in transmit status word
// - receive CRC error flagged alongside dribbling bits flag
// - no-carrier flagged; two consecutive mean short-circuited medium
// - excessive collisions record reflectometer; equal pair means open medium
// - late collision flagged in transmit status word
// - initially deferred flag set when medium busy before first attempt
// - heartbeat fail flagged when collision-detect check fails
// - receive overflow flag and separate too-long flag
// - received frame length written into receive status word
// - frames lost for lack of buffer while receive suspended counted in missed-frames counter
// - failed initialization shown by status register flag
// - frame while suspended and descriptor host-owned: discard, count missed
module eld_loopback (
	input  wire logic                      clk_i,
	input  wire logic                      rst_i,
	input  wire logic                      wb_cyc_i,
	input  wire logic                      wb_stb_i,
	input  wire logic                      wb_we_i,
	input  wire logic [4:0]                wb_adr_i,
	input  wire logic [3:0]                wb_sel_i,
	input  wire logic [31:0]               wb_dat_i,
	output logic      [31:0]               wb_dat_o,
	output logic                           wb_ack_o,
	input  wire logic [7:0]                mac_tx_data_i,
	input  wire logic                      mac_tx_valid_i,
	output logic      [7:0]                mac_rx_data_o,
	output logic                           mac_rx_valid_o,
	output logic      [7:0]                line_tx_data_o,
	output logic                           line_tx_en_o,
	input  wire logic [7:0]                line_rx_data_i,
	input  wire logic                      line_rx_valid_i,
	input  wire logic                      tx_busy_i,
	input  wire logic                      tx_suspend_i,
	input  wire logic                      tx_poll_i,
	input  wire logic                      tx_done_i,
	input  wire logic [eld_pkg::CC_W-1:0]  tx_collisions_i,
	input  wire logic                      tx_deferred_i,
	input  wire logic                      tx_excess_col_i,
	input  wire logic                      tx_late_col_i,
	input  wire logic                      tx_no_carrier_i,
	input  wire logic                      tx_heartbeat_fail_i,
	input  wire logic [eld_pkg::TDR_W-1:0] tx_tdr_i,
	input  wire logic                      rx_busy_i,
	input  wire logic                      rx_suspend_i,
	input  wire logic                      rx_frame_i,
	input  wire logic                      rx_desc_avail_i,
	input  wire logic                      rx_addr_match_i,
	input  wire logic                      rx_frame_ok_i,
	input  wire logic [eld_pkg::FL_W-1:0]  rx_length_i,
	input  wire logic                      rx_crc_err_i,
	input  wire logic                      rx_dribble_i,
	input  wire logic                      rx_overflow_i,
	input  wire logic                      rx_too_long_i,
	input  wire logic                      init_fail_i,
	output logic      [1:0]                op_mode_o,
	output logic                           tx_run_o,
	output logic                           rx_run_o,
	output logic                           rx_store_o,
	output logic                           tx_status_we_o,
	output logic      [31:0]               tx_status_word_o,
	output logic                           rx_status_we_o,
	output logic      [31:0]               rx_status_word_o
);
	// ========================================
	// register bus
	logic        wb_req;
	logic        wb_wr;
	logic        wb_rd;
	logic [31:0] rx_list_base_register;
	logic [31:0] tx_list_base_register;
	logic [eld_pkg::MFC_W-1:0] missed_frames;
	logic        init_failure_flag;
	logic        short_circuit;
	logic        open_circuit;
	logic        prev_no_carrier;
	logic        prev_excess;
	logic [eld_pkg::TDR_W-1:0] prev_tdr;
	eld_pkg::eld_mode_t   operating_mode_field;
	eld_pkg::eld_pstate_t tx_process_state;
	eld_pkg::eld_pstate_t rx_process_state;
	logic        cmd_tx_start;
	logic        cmd_tx_stop;
	logic        cmd_rx_start;
	logic        cmd_rx_stop;
	logic        missed_inc;
	logic        rx_accept;
	logic [31:0] next_rd;
	logic [31:0] status_value;

	function automatic logic [31:0] merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	function automatic logic both_stopped(input eld_pkg::eld_pstate_t t,
		input eld_pkg::eld_pstate_t r);
		return (t == eld_pkg::PS_STOPPED) && (r == eld_pkg::PS_STOPPED);
	endfunction : both_stopped

	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wb_wr  = wb_req && wb_we_i;
	assign wb_rd  = wb_req && !wb_we_i;
	assign cmd_tx_start = wb_wr && (wb_adr_i == eld_pkg::ADR_OPMODE)
		&& wb_sel_i[0] && wb_dat_i[eld_pkg::CMD_TX_START];
	assign cmd_tx_stop  = wb_wr && (wb_adr_i == eld_pkg::ADR_OPMODE)
		&& wb_sel_i[0] && wb_dat_i[eld_pkg::CMD_TX_STOP];
	assign cmd_rx_start = wb_wr && (wb_adr_i == eld_pkg::ADR_OPMODE)
		&& wb_sel_i[0] && wb_dat_i[eld_pkg::CMD_RX_START];
	assign cmd_rx_stop  = wb_wr && (wb_adr_i == eld_pkg::ADR_OPMODE)
		&& wb_sel_i[0] && wb_dat_i[eld_pkg::CMD_RX_STOP];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_req;
		end
	end

	always_comb begin
		status_value = eld_pkg::ZERO32;
		status_value[eld_pkg::ST_TX_LSB +: 2] = tx_process_state;
		status_value[eld_pkg::ST_RX_LSB +: 2] = rx_process_state;
		status_value[eld_pkg::ST_INIT_FAIL] = init_failure_flag;
		status_value[eld_pkg::ST_SHORT] = short_circuit;
		status_value[eld_pkg::ST_OPEN] = open_circuit;
	end

	always_comb begin
		next_rd = eld_pkg::ZERO32;
		case (wb_adr_i)
			eld_pkg::ADR_RX_BASE: next_rd = rx_list_base_register;
			eld_pkg::ADR_TX_BASE: next_rd = tx_list_base_register;
			eld_pkg::ADR_STATUS:  next_rd = status_value;
			eld_pkg::ADR_OPMODE:  next_rd[1:0] = operating_mode_field;
			eld_pkg::ADR_MISSED:  next_rd[eld_pkg::MFC_W-1:0] = missed_frames;
			eld_pkg::ADR_TX_STAT: next_rd = tx_status_word_o;
			eld_pkg::ADR_RX_STAT: next_rd = rx_status_word_o;
			default:              next_rd = eld_pkg::ZERO32;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= eld_pkg::ZERO32;
		end else if (wb_rd) begin
			wb_dat_o <= next_rd;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_list_base_register <= eld_pkg::ZERO32;
			tx_list_base_register <= eld_pkg::ZERO32;
		end else if (wb_wr && wb_adr_i == eld_pkg::ADR_RX_BASE) begin
			rx_list_base_register <= merge(rx_list_base_register,
				wb_dat_i, wb_sel_i);
		end else if (wb_wr && wb_adr_i == eld_pkg::ADR_TX_BASE) begin
			tx_list_base_register <= merge(tx_list_base_register,
				wb_dat_i, wb_sel_i);
		end
	end

	// ========================================
	// operating mode
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			operating_mode_field <= eld_pkg::OM_NORMAL;
		end else if (wb_wr && wb_adr_i == eld_pkg::ADR_OPMODE && wb_sel_i[0]
			&& both_stopped(tx_process_state, rx_process_state)) begin
			case (wb_dat_i[eld_pkg::OM_LSB +: 2])
				eld_pkg::OM_NORMAL:
					operating_mode_field <= eld_pkg::OM_NORMAL;
				eld_pkg::OM_INT_LOOP:
					operating_mode_field <= eld_pkg::OM_INT_LOOP;
				eld_pkg::OM_EXT_LOOP:
					operating_mode_field <= eld_pkg::OM_EXT_LOOP;
				default: operating_mode_field <= operating_mode_field;
			endcase
		end
	end
	assign op_mode_o = operating_mode_field;

	// ========================================
	// transmit and receive process states
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_process_state <= eld_pkg::PS_STOPPED;
		end else begin
			case (tx_process_state)
				eld_pkg::PS_STOPPED: begin
					if (cmd_tx_start) begin
						tx_process_state <= eld_pkg::PS_RUNNING;
					end
				end
				eld_pkg::PS_RUNNING: begin
					if (cmd_tx_stop && !tx_busy_i) begin
						tx_process_state <= eld_pkg::PS_STOPPED;
					end else if (tx_suspend_i) begin
						tx_process_state <= eld_pkg::PS_SUSPENDED;
					end
				end
				eld_pkg::PS_SUSPENDED: begin
					if (cmd_tx_stop) begin
						tx_process_state <= eld_pkg::PS_STOPPED;
					end else if (tx_poll_i) begin
						tx_process_state <= eld_pkg::PS_RUNNING;
					end
				end
				default: tx_process_state <= eld_pkg::PS_STOPPED;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_process_state <= eld_pkg::PS_STOPPED;
		end else begin
			case (rx_process_state)
				eld_pkg::PS_STOPPED: begin
					if (cmd_rx_start) begin
						rx_process_state <= eld_pkg::PS_RUNNING;
					end
				end
				eld_pkg::PS_RUNNING: begin
					if (cmd_rx_stop && !rx_busy_i) begin
						rx_process_state <= eld_pkg::PS_STOPPED;
					end else if (rx_suspend_i) begin
						rx_process_state <= eld_pkg::PS_SUSPENDED;
					end
				end
				eld_pkg::PS_SUSPENDED: begin
					if (cmd_rx_stop) begin
						rx_process_state <= eld_pkg::PS_STOPPED;
					end else if (rx_frame_i && rx_desc_avail_i) begin
						rx_process_state <= eld_pkg::PS_RUNNING;
					end
				end
				default: rx_process_state <= eld_pkg::PS_STOPPED;
			endcase
		end
	end
	assign tx_run_o = (tx_process_state == eld_pkg::PS_RUNNING);
	assign rx_run_o = (rx_process_state == eld_pkg::PS_RUNNING);

	// ========================================
	// loopback routing
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			line_tx_data_o <= 8'h00;
			line_tx_en_o   <= 1'b0;
			mac_rx_data_o  <= 8'h00;
			mac_rx_valid_o <= 1'b0;
		end else if (operating_mode_field == eld_pkg::OM_INT_LOOP) begin
			line_tx_data_o <= 8'h00;
			line_tx_en_o   <= 1'b0;
			mac_rx_data_o  <= mac_tx_data_i;
			mac_rx_valid_o <= mac_tx_valid_i;
		end else begin
			line_tx_data_o <= mac_tx_data_i;
			line_tx_en_o   <= mac_tx_valid_i;
			mac_rx_data_o  <= line_rx_data_i;
			mac_rx_valid_o <= line_rx_valid_i;
		end
	end

	// ========================================
	// receive acceptance and missed frames
	assign missed_inc = rx_frame_i && !rx_desc_avail_i
		&& (rx_process_state == eld_pkg::PS_SUSPENDED);
	assign rx_accept = rx_frame_i && rx_desc_avail_i
		&& (rx_process_state != eld_pkg::PS_STOPPED)
		&& rx_addr_match_i && rx_frame_ok_i;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			missed_frames <= '0;
		end else if (wb_rd && wb_adr_i == eld_pkg::ADR_MISSED) begin
			missed_frames <= missed_inc ? eld_pkg::MFC_ONE : '0;
		end else if (missed_inc) begin
			missed_frames <= missed_frames + eld_pkg::MFC_ONE;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_store_o       <= 1'b0;
			rx_status_we_o   <= 1'b0;
			rx_status_word_o <= eld_pkg::ZERO32;
		end else begin
			rx_store_o     <= rx_accept;
			rx_status_we_o <= rx_accept;
			if (rx_accept) begin
				rx_status_word_o <= eld_pkg::ZERO32;
				rx_status_word_o[eld_pkg::RX_CRC_ERR]  <= rx_crc_err_i;
				rx_status_word_o[eld_pkg::RX_DRIBBLE]  <= rx_dribble_i;
				rx_status_word_o[eld_pkg::RX_OVERFLOW] <= rx_overflow_i;
				rx_status_word_o[eld_pkg::RX_TOO_LONG] <= rx_too_long_i;
				rx_status_word_o[eld_pkg::RX_FL_LSB +: eld_pkg::FL_W]
					<= rx_length_i;
			end
		end
	end

	// ========================================
	// transmit status word
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_status_we_o   <= 1'b0;
			tx_status_word_o <= eld_pkg::ZERO32;
		end else begin
			tx_status_we_o <= tx_done_i;
			if (tx_done_i) begin
				tx_status_word_o <= eld_pkg::ZERO32;
				tx_status_word_o[eld_pkg::TX_CC_LSB +: eld_pkg::CC_W]
					<= tx_collisions_i;
				tx_status_word_o[eld_pkg::TX_NO_CARRIER]
					<= tx_no_carrier_i;
				tx_status_word_o[eld_pkg::TX_EXC_COL] <= tx_excess_col_i;
				if (tx_excess_col_i) begin
					tx_status_word_o[eld_pkg::TX_TDR_LSB +: eld_pkg::TDR_W]
						<= tx_tdr_i;
				end
				tx_status_word_o[eld_pkg::TX_LATE_COL] <= tx_late_col_i;
				tx_status_word_o[eld_pkg::TX_DEFER] <= tx_deferred_i;
				tx_status_word_o[eld_pkg::TX_HB_FAIL]
					<= tx_heartbeat_fail_i;
			end
		end
	end

	// ========================================
	// medium fault detection
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prev_no_carrier <= 1'b0;
			prev_excess     <= 1'b0;
			prev_tdr        <= '0;
		end else if (tx_done_i) begin
			prev_no_carrier <= tx_no_carrier_i;
			prev_excess     <= tx_excess_col_i;
			prev_tdr        <= tx_tdr_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			short_circuit <= 1'b0;
			open_circuit  <= 1'b0;
		end else begin
			if (tx_done_i && tx_no_carrier_i && prev_no_carrier) begin
				short_circuit <= 1'b1;
			end else if (wb_wr && wb_adr_i == eld_pkg::ADR_STATUS
				&& wb_sel_i[0] && wb_dat_i[eld_pkg::ST_SHORT]) begin
				short_circuit <= 1'b0;
			end
			if (tx_done_i && tx_excess_col_i && prev_excess
				&& tx_tdr_i == prev_tdr) begin
				open_circuit <= 1'b1;
			end else if (wb_wr && wb_adr_i == eld_pkg::ADR_STATUS
				&& wb_sel_i[0] && wb_dat_i[eld_pkg::ST_OPEN]) begin
				open_circuit <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			init_failure_flag <= 1'b0;
		end else if (init_fail_i) begin
			init_failure_flag <= 1'b1;
		end
	end
endmodule : eld_loopback

//--- tb/eld_loopback_props.sv
`timescale 1ns/1ps
// ========================================
// port checker
module eld_loopback_props (
	input wire logic                      clk_i,
	input wire logic                      rst_i,
	input wire logic                      wb_cyc_i,
	input wire logic                      wb_stb_i,
	input wire logic                      wb_ack_o,
	input wire logic [7:0]                mac_tx_data_i,
	input wire logic                      mac_tx_valid_i,
	input wire logic [7:0]                mac_rx_data_o,
	input wire logic                      mac_rx_valid_o,
	input wire logic [7:0]                line_tx_data_o,
	input wire logic                      line_tx_en_o,
	input wire logic [7:0]                line_rx_data_i,
	input wire logic                      line_rx_valid_i,
	input wire logic                      tx_done_i,
	input wire logic [eld_pkg::CC_W-1:0]  tx_collisions_i,
	input wire logic                      tx_excess_col_i,
	input wire logic [eld_pkg::TDR_W-1:0] tx_tdr_i,
	input wire logic                      rx_frame_i,
	input wire logic                      rx_desc_avail_i,
	input wire logic                      rx_addr_match_i,
	input wire logic                      rx_frame_ok_i,
	input wire logic [eld_pkg::FL_W-1:0]  rx_length_i,
	input wire logic                      rx_crc_err_i,
	input wire logic                      rx_dribble_i,
	input wire logic [1:0]                op_mode_o,
	input wire logic                      tx_run_o,
	input wire logic                      rx_run_o,
	input wire logic                      rx_store_o,
	input wire logic                      tx_status_we_o,
	input wire logic [31:0]               tx_status_word_o,
	input wire logic                      rx_status_we_o,
	input wire logic [31:0]               rx_status_word_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_ack;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	bus_ack_pulse_a: assert property (s_req |=> s_ack)
		else $error("bus ack not a single pulse");
	int_loop_echo_a: assert property (op_mode_o == eld_pkg::OM_INT_LOOP
		&& tx_run_o && rx_run_o && mac_tx_valid_i |=> mac_rx_valid_o
		&& mac_rx_data_o == $past(mac_tx_data_i)) else $error("no echo");
	int_line_quiet_a: assert property (op_mode_o == eld_pkg::OM_INT_LOOP
		&& $stable(op_mode_o) |-> !line_tx_en_o) else $error("line on");
	ext_line_tx_a: assert property (op_mode_o == eld_pkg::OM_EXT_LOOP
		&& tx_run_o && mac_tx_valid_i |=> line_tx_en_o
		&& line_tx_data_o == $past(mac_tx_data_i)) else $error("no tx");
	ext_line_rx_a: assert property (op_mode_o == eld_pkg::OM_EXT_LOOP
		&& rx_run_o && line_rx_valid_i |=> mac_rx_valid_o
		&& mac_rx_data_o == $past(line_rx_data_i)) else $error("no rx");
	tx_word_a: assert property (tx_done_i |=> tx_status_we_o
		&& tx_status_word_o[5:2] == $past(tx_collisions_i)
		&& tx_status_word_o[19:10] == ($past(tx_excess_col_i)
		? $past(tx_tdr_i) : 10'h000)) else $error("tx word wrong");
	rx_word_a: assert property (rx_store_o |-> rx_status_we_o
		&& rx_status_word_o[29:16] == $past(rx_length_i)
		&& rx_status_word_o[1] == $past(rx_crc_err_i)
		&& rx_status_word_o[2] == $past(rx_dribble_i))
		else $error("rx word wrong");
	rx_filter_a: assert property (rx_frame_i
		&& !(rx_addr_match_i && rx_frame_ok_i) |=> !rx_store_o)
		else $error("bad frame stored");
	rx_accept_a: assert property (rx_frame_i && rx_run_o
		&& rx_desc_avail_i && rx_addr_match_i && rx_frame_ok_i |=> rx_store_o)
		else $error("good frame dropped");
	mode_hold_a: assert property ((tx_run_o || rx_run_o)
		|=> $stable(op_mode_o)) else $error("mode changed while running");
endmodule : eld_loopback_props

bind eld_loopback eld_loopback_props i_eld_loopback_props (
	.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .mac_tx_data_i,
	.mac_tx_valid_i, .mac_rx_data_o, .mac_rx_valid_o, .line_tx_data_o,
	.line_tx_en_o, .line_rx_data_i, .line_rx_valid_i, .tx_done_i,
	.tx_collisions_i, .tx_excess_col_i, .tx_tdr_i, .rx_frame_i,
	.rx_desc_avail_i, .rx_addr_match_i, .rx_frame_ok_i, .rx_length_i,
	.rx_crc_err_i, .rx_dribble_i, .op_mode_o, .tx_run_o, .rx_run_o,
	.rx_store_o, .tx_status_we_o, .tx_status_word_o, .rx_status_we_o,
	.rx_status_word_o
);

//--- tb/eld_medium.sv
`timescale 1ns/1ps
// ========================================
// medium: wire echo plus a foreign station
module eld_medium (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic [7:0] tx_data_i,
	input  wire logic       tx_en_i,
	input  wire logic       inject_i,
	input  wire logic [7:0] inject_data_i,
	output logic      [7:0] rx_data_o,
	output logic            rx_valid_o
);
	always_ff @(posedge clk_i) begin
		rx_valid_o <= !rst_i && (tx_en_i || inject_i);
		if (rst_i)
			rx_data_o <= 8'h00;
		else if (inject_i)
			rx_data_o <= inject_data_i;
		else if (tx_en_i)
			rx_data_o <= tx_data_i;
		else
			rx_data_o <= ~rx_data_o;
	end
endmodule : eld_medium

//--- tb/eld_loopback_tb.sv
`timescale 1ns/1ps
module eld_loopback_tb;
	logic clk_i = 1'h0, rst_i = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0;
	logic wb_we_i = 1'h0, mac_tx_valid_i = 1'h0, inject_i = 1'h0;
	logic [4:0] wb_adr_i = 5'h00;
	logic [3:0] wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, tx_status_word_o, rx_status_word_o;
	logic [7:0] mac_tx_data_i = 8'h00, inject_data_i = 8'h00;
	logic [7:0] mac_rx_data_o, line_tx_data_o, line_rx_data_i;
	logic wb_ack_o, mac_rx_valid_o, line_tx_en_o, line_rx_valid_i, tx_run_o;
	logic rx_run_o, rx_store_o, tx_status_we_o, rx_status_we_o;
	logic [1:0] op_mode_o;
	logic tx_busy_i = 1'h0, tx_suspend_i = 1'h0, tx_poll_i = 1'h0;
	logic tx_done_i = 1'h0, tx_deferred_i = 1'h0, tx_excess_col_i = 1'h0;
	logic tx_late_col_i = 1'h0, tx_no_carrier_i = 1'h0, init_fail_i = 1'h0;
	logic tx_heartbeat_fail_i = 1'h0, rx_busy_i = 1'h0, rx_suspend_i = 1'h0;
	logic rx_frame_i = 1'h0, rx_desc_avail_i = 1'h0, rx_addr_match_i = 1'h0;
	logic rx_frame_ok_i = 1'h0, rx_crc_err_i = 1'h0, rx_dribble_i = 1'h0;
	logic rx_overflow_i = 1'h0, rx_too_long_i = 1'h0;
	logic [3:0] tx_collisions_i = 4'h0;
	logic [9:0] tx_tdr_i = 10'h000;
	logic [13:0] rx_length_i = 14'h0000;
	int failures = 0;
	int n_checks = 0;
	logic [4:0] adrs [6] = '{eld_pkg::ADR_STATUS, eld_pkg::ADR_OPMODE,
		eld_pkg::ADR_MISSED, eld_pkg::ADR_TX_STAT, eld_pkg::ADR_RX_STAT, 5'h1C};
	logic [6:0] rx_tab [7] = '{7'h70, 7'h78, 7'h7C, 7'h72, 7'h71, 7'h50, 7'h60};
	logic [18:0] tx_tab [7] = '{{10'h3FF, 5'h01, 4'h1}, {10'h000, 5'h02, 4'h3},
		{10'h000, 5'h08, 4'h1}, {10'h000, 5'h10, 4'h0}, {10'h000, 5'h10, 4'h0},
		{10'h005, 5'h04, 4'hF}, {10'h005, 5'h04, 4'hF}};

	always #10 clk_i = ~clk_i;

	eld_loopback i_eld_loopback (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .mac_tx_data_i,
		.mac_tx_valid_i, .mac_rx_data_o, .mac_rx_valid_o, .line_tx_data_o,
		.line_tx_en_o, .line_rx_data_i, .line_rx_valid_i, .tx_busy_i,
		.tx_suspend_i, .tx_poll_i, .tx_done_i, .tx_collisions_i, .tx_deferred_i,
		.tx_excess_col_i, .tx_late_col_i, .tx_no_carrier_i, .tx_heartbeat_fail_i,
		.tx_tdr_i, .rx_busy_i, .rx_suspend_i, .rx_frame_i, .rx_desc_avail_i,
		.rx_addr_match_i, .rx_frame_ok_i, .rx_length_i, .rx_crc_err_i,
		.rx_dribble_i, .rx_overflow_i, .rx_too_long_i, .init_fail_i, .op_mode_o,
		.tx_run_o, .rx_run_o, .rx_store_o, .tx_status_we_o, .tx_status_word_o,
		.rx_status_we_o, .rx_status_word_o);
	eld_medium i_eld_medium (.clk_i, .rst_i, .tx_data_i(line_tx_data_o),
		.tx_en_i(line_tx_en_o), .inject_i, .inject_data_i,
		.rx_data_o(line_rx_data_i), .rx_valid_o(line_rx_valid_i));

	// ========================================
	// tasks
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : finish_test
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wb(input logic we, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'h1 && n < 50);
		q = wb_dat_o;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
		if (wb_ack_o !== 1'h1) begin
			failures++;
			finish_test();
		end
		@(posedge clk_i);
	endtask : wb
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'h1, a, d, q);
	endtask : wr
	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb(1'h0, a, 32'h0, q);
		check(q, e);
	endtask : rd
	task automatic stop_all(input logic [1:0] m);
		logic [31:0] q;
		int n;
		wr(eld_pkg::ADR_OPMODE, {26'h0, 4'hA, m});
		n = 0;
		do begin
			wb(1'h0, eld_pkg::ADR_STATUS, 32'h0, q);
			n++;
		end while (q[3:0] !== 4'h0 && n < 20);
		check(32'(q[3:0]), 32'h0);
	endtask : stop_all
	task automatic send(input logic [7:0] b, input logic ext);
		mac_tx_data_i <= b;
		mac_tx_valid_i <= 1'h1;
		@(posedge clk_i);
		mac_tx_valid_i <= 1'h0;
		mac_tx_data_i <= ~b;
		@(posedge clk_i);
		check(32'(line_tx_en_o), 32'(ext));
		if (ext) begin
			check(32'(line_tx_data_o), 32'(b));
			repeat (2) @(posedge clk_i);
		end
		check(32'(mac_rx_valid_o), 32'h1);
		check(32'(mac_rx_data_o), 32'(b));
	endtask : send
	task automatic rx_ev(input logic [6:0] f, input logic [13:0] len);
		{rx_desc_avail_i, rx_addr_match_i, rx_frame_ok_i, rx_crc_err_i,
			rx_dribble_i, rx_overflow_i, rx_too_long_i} <= f;
		rx_length_i <= len;
		rx_frame_i <= 1'h1;
		@(posedge clk_i);
		rx_frame_i <= 1'h0;
		@(posedge clk_i);
		check(32'(rx_store_o), 32'(&f[6:4]));
		if (&f[6:4]) begin
			check(32'(rx_status_we_o), 32'h1);
			check(rx_status_word_o, {2'h0, len, 12'h000, f[0], f[2], f[3], f[1]});
		end
	endtask : rx_ev
	task automatic tx_ev(input logic [18:0] e);
		{tx_tdr_i, tx_no_carrier_i, tx_late_col_i, tx_excess_col_i,
			tx_heartbeat_fail_i, tx_deferred_i, tx_collisions_i} <= e;
		tx_done_i <= 1'h1;
		@(posedge clk_i);
		tx_done_i <= 1'h0;
		@(posedge clk_i);
		check(32'(tx_status_we_o), 32'h1);
		check(tx_status_word_o, {12'h000, (e[6] ? e[18:9] : 10'h000), 1'h0, e[8:6], e[3:0], e[5:4]});
	endtask : tx_ev

	// ========================================
	// main sequence
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'h0;
		@(posedge clk_i);
		foreach (adrs[i]) rd(adrs[i], 32'h0);
		wr(eld_pkg::ADR_RX_BASE, 32'h0001_2340);
		wr(eld_pkg::ADR_TX_BASE, 32'h0005_6780);
		rd(eld_pkg::ADR_RX_BASE, 32'h0001_2340);
		rd(eld_pkg::ADR_TX_BASE, 32'h0005_6780);
		$display("test reset done");
		wr(eld_pkg::ADR_OPMODE, 32'h3);
		rd(eld_pkg::ADR_OPMODE, 32'h0);
		wr(eld_pkg::ADR_OPMODE, 32'h1);
		wr(eld_pkg::ADR_OPMODE, 32'h15);
		rd(eld_pkg::ADR_STATUS, 32'h5);
		wr(eld_pkg::ADR_OPMODE, 32'h2);
		rd(eld_pkg::ADR_OPMODE, 32'h1);
		for (int i = 0; i < 4; i++) send(8'hA0 + 8'(i), 1'h0);
		$display("test internal loop done");
		for (int i = 0; i < 7; i++) rx_ev(rx_tab[i], 14'h0040 + 14'(i));
		foreach (tx_tab[i]) tx_ev(tx_tab[i]);
		rd(eld_pkg::ADR_TX_STAT, 32'h0000_147C);
		rd(eld_pkg::ADR_STATUS, 32'h65);
		wr(eld_pkg::ADR_STATUS, 32'h60);
		rd(eld_pkg::ADR_STATUS, 32'h05);
		$display("test status words done");
		rx_suspend_i <= 1'h1;
		@(posedge clk_i);
		rx_suspend_i <= 1'h0;
		rd(eld_pkg::ADR_STATUS, 32'h09);
		rx_ev(7'h30, 14'h0040);
		rd(eld_pkg::ADR_MISSED, 32'h1);
		rd(eld_pkg::ADR_MISSED, 32'h0);
		rx_ev(7'h70, 14'h0050);
		rd(eld_pkg::ADR_STATUS, 32'h05);
		$display("test missed frames done");
		tx_busy_i <= 1'h1;
		wr(eld_pkg::ADR_OPMODE, 32'h29);
		rd(eld_pkg::ADR_STATUS, 32'h01);
		tx_busy_i <= 1'h0;
		stop_all(2'h1);
		wr(eld_pkg::ADR_OPMODE, 32'h2);
		wr(eld_pkg::ADR_OPMODE, 32'h16);
		rd(eld_pkg::ADR_OPMODE, 32'h2);
		send(8'h5A, 1'h1);
		send(8'hC3, 1'h1);
		inject_data_i <= 8'h99;
		inject_i <= 1'h1;
		@(posedge clk_i);
		inject_i <= 1'h0;
		@(posedge clk_i);
		@(posedge clk_i);
		check(32'(mac_rx_data_o), 32'h99);
		stop_all(2'h2);
		wr(eld_pkg::ADR_OPMODE, 32'h0);
		rd(eld_pkg::ADR_OPMODE, 32'h0);
		$display("test external loop done");
		init_fail_i <= 1'h1;
		@(posedge clk_i);
		init_fail_i <= 1'h0;
		rd(eld_pkg::ADR_STATUS, 32'h10);
		$display("test init fail done");
		finish_test();
	end
endmodule : eld_loopback_tb
